// ==== core/pmfct_consts.vh ====
// Constants for the power-management fixed control and timer block
`ifndef PMFCT_CONSTS_VH
`define PMFCT_CONSTS_VH

// Register select codes
`define PMFCT_SEL_CTRL_A      2'h0
`define PMFCT_SEL_CTRL_B      2'h1
`define PMFCT_SEL_TIMER       2'h2
`define PMFCT_SEL_ARB         2'h3

// Control register field positions
`define PMFCT_ROUTE_BIT       0
`define PMFCT_WAKE_BIT        1
`define PMFCT_RLS_BIT         2
`define PMFCT_TYPE_LO         10
`define PMFCT_TYPE_HI         12
`define PMFCT_TRIG_BIT        13
`define PMFCT_ARB_BIT         0

// Reset values
`define PMFCT_CTRL_RST        16'h0000
`define PMFCT_ARB_RST         8'h00
`define PMFCT_TMR_RST         32'h00000000

// Timer tick: 3.579545 MHz from 10 MHz by phase accumulator
`define PMFCT_TICK_INC        24'h5BA2A6
`define PMFCT_TICK_W          24

`endif

// ==== core/pmfct_tick_gen.v ====
// Tick enable generator for the power-management timer rate
`timescale 1ns/1ns
`default_nettype none
`include "pmfct_consts.vh"

module pmfct_tick_gen (
    input  wire clk_sys,
    input  wire sys_rst,
    input  wire run,
    output reg  tick
);
    reg  [`PMFCT_TICK_W-1:0] accReg;
    wire [`PMFCT_TICK_W:0]   sumNext;

    assign sumNext = {1'b0, accReg} + {1'b0, `PMFCT_TICK_INC};

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            accReg <= {`PMFCT_TICK_W{1'b0}};
            tick   <= 1'b0;
        end else if (run) begin
            accReg <= sumNext[`PMFCT_TICK_W-1:0];
            tick   <= sumNext[`PMFCT_TICK_W];
        end else begin
            tick   <= 1'b0;
        end
    end
endmodule // pmfct_tick_gen

`default_nettype wire

// ==== core/pmfct_timer.v ====
// Free-running power-management timer, 24 or 32 bits
`timescale 1ns/1ns
`default_nettype none
`include "pmfct_consts.vh"

module pmfct_timer (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        tick,
    input  wire        wide,
    output reg  [31:0] count,
    output reg         msbToggle
);
    wire [31:0] countInc;
    wire        msbOld;
    wire        msbNew;

    assign countInc = count + 32'h00000001;
    assign msbOld = wide ? count[31] : count[23];
    assign msbNew = wide ? countInc[31] : countInc[23];

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            count     <= `PMFCT_TMR_RST;
            msbToggle <= 1'b0;
        end else begin
            msbToggle <= tick & (msbOld ^ msbNew);
            if (tick) begin
                count <= wide ? countInc : {8'h00, countInc[23:0]};
            end
        end
    end
endmodule // pmfct_timer

`default_nettype wire

// ==== core/pmfct_top.v ====
// Power-management fixed control, timer and arbiter registers
// ----------------------------------------------------------------
// Overview of operation
// R01: Events go to SCI when route bit set, else to SMI.
// R02: Only hardware changes route bit; software writes keep it.
// R03: Wake bit set lets bus master request move C3 CPU to C0.
// R04: Global release bit is write-only; writing raises firmware SMI.
// R05: Firmware enable gates that event; firmware status latches it.
// R06: Software writes release when freeing lock with pending set.
// R07: Software treats bits 3-8 reserved and ignores bit 9.
// R08: Sleep-type field bits 10-12 picks state entered on trigger.
// R09: Software writes each sleep-type value into its own block.
// R10: Sleep trigger bit 13 write-only, reads zero, starts sleep.
// R11: Control bits 14 and 15 read zero.
// R12: Two control blocks, each aligned, byte and word access.
// R13: Timer register read-only, full 32-bit read of count.
// R14: Timer 24 or 32 bits wide; flag reports the width.
// R15: Toggle of top implemented timer bit sets timer status.
// R16: Timer increments at 3.579545 MHz while in S0.
// R17: Timer stops when clock halts, resumes from held value.
// R18: Timer bits 24-31 read zero for a 24-bit timer.
// R19: Arbiter control is one naturally aligned byte.
// R20: Arbiter disable set gives CPU ownership, clear lets arbiter grant.
// R21: Software keeps arbiter disable clear in C0, C1, C2.
// R22: Software ignores bits of unsupported features.
// R23: Missing bits in a block read zero, ignore writes.
// R24: Timer enable set raises SCI when timer status sets.
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "pmfct_consts.vh"

module pmfct_top (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        regRead,
    input  wire        regWrite,
    input  wire [1:0]  regSel,
    input  wire [1:0]  byteEn,
    input  wire [15:0] wrData,
    output reg  [31:0] rdData,
    input  wire        timerWide,
    input  wire [15:0] blockAMask,
    input  wire        routeSetPin,
    input  wire        routeClrPin,
    input  wire        busMasterReqPin,
    input  wire        cpuInC3,
    input  wire        timerEnable,
    input  wire        timerStsClr,
    input  wire        firmwareEventEnable,
    input  wire        firmwareStsClr,
    input  wire        inWorkingState,
    output wire        timerWidthFlag,
    output reg         sciEvent,
    output reg         smiEvent,
    output reg         cpuWakeToC0,
    output reg         sleepStart,
    output reg  [2:0]  sleepTypeA,
    output reg  [2:0]  sleepTypeB,
    output reg         timerStatusFlag,
    output reg         firmwareEventStatus,
    output reg         arbiterDisable
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    reg [4:0] syncA;
    reg [4:0] syncB;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            syncA <= 5'h00;
            syncB <= 5'h00;
        end else begin
            syncA <= {inWorkingState, cpuInC3, busMasterReqPin,
                      routeClrPin, routeSetPin};
            syncB <= syncA;
        end
    end

    wire routeSet = syncB[0];
    wire routeClr = syncB[1];
    wire bmReq    = syncB[2];
    wire inC3     = syncB[3];
    wire inS0     = syncB[4];

    // ------------------------------------------------------------
    // Byte-lane merge
    // ------------------------------------------------------------
    // R12: byte lane merge
    function [15:0] laneMerge;
        input [15:0] oldV;
        input [15:0] newV;
        input [1:0]  be;
        begin
            laneMerge = {be[1] ? newV[15:8] : oldV[15:8],
                         be[0] ? newV[7:0]  : oldV[7:0]};
        end
    endfunction

    // Write strobe that reaches the block owning a bit
    function ownHit;
        input hitA;
        input hitB;
        input ownA;
        begin
            ownHit = (hitA && ownA) || (hitB && !ownA);
        end
    endfunction

    // Control block read view, unowned bits zero
    function [15:0] ctlRead;
        input [15:0] ctl;
        input [15:0] view;
        input [15:0] mask;
        begin
            ctlRead = ({ctl[15:13], ctl[12:10], 10'h000} | view) &
                      mask;
        end
    endfunction

    // ------------------------------------------------------------
    // Register strobes
    // ------------------------------------------------------------
    // R12: one strobe per block
    wire wrA   = regWrite && (regSel == `PMFCT_SEL_CTRL_A);
    wire wrB   = regWrite && (regSel == `PMFCT_SEL_CTRL_B);
    wire wrArb = regWrite && (regSel == `PMFCT_SEL_ARB);

    // ------------------------------------------------------------
    // Control blocks
    // ------------------------------------------------------------
    reg        eventRoute_reg;
    reg        bmWake_reg;
    reg [15:0] ctlA_reg;
    reg [15:0] ctlB_reg;
    reg        trigA;
    reg        trigB;
    reg        relPulse;

    wire [15:0] mA = blockAMask;
    wire [15:0] mB = ~blockAMask;
    wire [15:0] wA = laneMerge(16'h0000, wrData, byteEn);
    wire [15:0] wB = wA;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            eventRoute_reg <= 1'b0;
            bmWake_reg     <= 1'b0;
            ctlA_reg       <= `PMFCT_CTRL_RST;
            ctlB_reg       <= `PMFCT_CTRL_RST;
            trigA          <= 1'b0;
            trigB          <= 1'b0;
            relPulse       <= 1'b0;
        end else begin
            // R02: route bit hardware-only
            if (routeSet)
                eventRoute_reg <= 1'b1;
            else if (routeClr)
                eventRoute_reg <= 1'b0;
            // R12: per-block byte/word writes
            if (wrA && byteEn[1]) begin
                ctlA_reg[12:10] <= wrData[12:10] & mA[12:10];
            end
            if (wrB && byteEn[1]) begin
                ctlB_reg[12:10] <= wrData[12:10] & mB[12:10];
            end
            // R23: bit owned by one block only
            if (byteEn[0] && ownHit(wrA, wrB, mA[`PMFCT_WAKE_BIT])) begin
                bmWake_reg <= wrData[`PMFCT_WAKE_BIT];
            end
            // R10: write-only sleep trigger
            trigA <= wrA && wA[`PMFCT_TRIG_BIT] && mA[`PMFCT_TRIG_BIT];
            trigB <= wrB && wB[`PMFCT_TRIG_BIT] && mB[`PMFCT_TRIG_BIT];
            // R04: release doorbell pulse
            relPulse <= byteEn[0] && wrData[`PMFCT_RLS_BIT] &&
                        ownHit(wrA, wrB, mA[`PMFCT_RLS_BIT]);
        end
    end

    // ------------------------------------------------------------
    // Sleep sequencing outputs
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            sleepStart <= 1'b0;
            sleepTypeA <= 3'h0;
            sleepTypeB <= 3'h0;
        end else begin
            // R08: selected sleep type presented
            sleepTypeA <= ctlA_reg[`PMFCT_TYPE_HI:`PMFCT_TYPE_LO];
            sleepTypeB <= ctlB_reg[`PMFCT_TYPE_HI:`PMFCT_TYPE_LO];
            sleepStart <= trigA | trigB;
        end
    end

    // ------------------------------------------------------------
    // Bus master wake and arbiter
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            cpuWakeToC0    <= 1'b0;
            arbiterDisable <= 1'b0;
        end else begin
            // R03: wake C3 only when enabled
            cpuWakeToC0 <= bmWake_reg && bmReq && inC3;
            // R19: single byte register, low lane
            // R20: arbiter disable control
            if (wrArb && byteEn[0])
                arbiterDisable <= wrData[`PMFCT_ARB_BIT];
        end
    end

    // ------------------------------------------------------------
    // Timer
    // ------------------------------------------------------------
    wire        tick;
    wire [31:0] tmrCount;
    wire        msbToggle;

    // R16: counts at timer rate in S0
    // R17: halts outside S0, holds value
    pmfct_tick_gen uTick (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .run     (inS0),
        .tick    (tick)
    );

    // R14: width select
    pmfct_timer uTimer (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .tick      (tick),
        .wide      (timerWide),
        .count     (tmrCount),
        .msbToggle (msbToggle)
    );

    assign timerWidthFlag = timerWide;

    wire timerEvt = msbToggle && timerEnable;
    wire rlsEvt   = relPulse && firmwareEventEnable;

    // ------------------------------------------------------------
    // Status flags and event routing
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            timerStatusFlag     <= 1'b0;
            firmwareEventStatus <= 1'b0;
            sciEvent            <= 1'b0;
            smiEvent            <= 1'b0;
        end else begin
            // R15: set wins over clear
            if (msbToggle)
                timerStatusFlag <= 1'b1;
            else if (timerStsClr)
                timerStatusFlag <= 1'b0;
            // R05: firmware gate and latch
            if (rlsEvt)
                firmwareEventStatus <= 1'b1;
            else if (firmwareStsClr)
                firmwareEventStatus <= 1'b0;
            // R01: route timer event; R24: gated by enable
            sciEvent <= timerEvt && eventRoute_reg;
            // R04: release goes to firmware as SMI when firmware enable set, whatever the route bit
            smiEvent <= (timerEvt && !eventRoute_reg) || rlsEvt;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [15:0] ctlView = {2'b00, 1'b0, 3'h0, 1'b0, 6'h00, 1'b0,
                           bmWake_reg, eventRoute_reg};
    wire [15:0] rdA = ctlRead(ctlA_reg, ctlView, mA);
    wire [15:0] rdB = ctlRead(ctlB_reg, ctlView, mB);

    // R18: upper byte zero when narrow
    wire [31:0] tmrView = timerWide ? tmrCount : {8'h00, tmrCount[23:0]};

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            rdData <= 32'h00000000;
        end else if (regRead) begin
            case (regSel)
                // R11: bits 13-15 read zero
                `PMFCT_SEL_CTRL_A: rdData <= {16'h0000,
                    laneMerge(16'h0000, rdA & 16'h1C03, byteEn)};
                `PMFCT_SEL_CTRL_B: rdData <= {16'h0000,
                    laneMerge(16'h0000, rdB & 16'h1C03, byteEn)};
                // R13: full timer read
                `PMFCT_SEL_TIMER: rdData <= tmrView;
                `PMFCT_SEL_ARB: rdData <= {31'h00000000, arbiterDisable};
                default: rdData <= 32'h00000000;
            endcase
        end
    end
endmodule // pmfct_top

`default_nettype wire

// ==== tb/pmfct_props.sv ====
// Assertion checker for the power-management fixed block
`timescale 1ns/1ns
`default_nettype none
module pmfct_props (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        regRead,
    input wire logic        regWrite,
    input wire logic [1:0]  regSel,
    input wire logic [1:0]  byteEn,
    input wire logic [15:0] wrData,
    input wire logic [31:0] rdData,
    input wire logic        timerWide,
    input wire logic [15:0] blockAMask,
    input wire logic        timerStsClr,
    input wire logic        firmwareEventEnable,
    input wire logic        firmwareStsClr,
    input wire logic        timerWidthFlag,
    input wire logic        smiEvent,
    input wire logic        sleepStart,
    input wire logic [2:0]  sleepTypeA,
    input wire logic        timerStatusFlag,
    input wire logic        firmwareEventStatus,
    input wire logic        arbiterDisable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // Access sequences
    // ----------------------------------------------------------------
    sequence sRdCtl;
        regRead && !regSel[1] ##1 !regRead;
    endsequence
    sequence sRdTmr;
        regRead && regSel == 2'h2 && !timerWide ##1 !regRead;
    endsequence
    sequence sWrArb;
        regWrite && regSel == 2'h3 && byteEn[0] ##1 !regWrite;
    endsequence
    sequence sWrTypA;
        regWrite && regSel == 2'h0 && byteEn[1]
            && blockAMask[12:10] == 3'h7 ##1 !regWrite;
    endsequence
    sequence sTrig;
        regWrite && !regSel[1] && byteEn[1] && wrData[13]
            && (regSel[0] ^ blockAMask[13]);
    endsequence
    sequence sRls;
        regWrite && !regSel[1] && byteEn[0] && wrData[2]
            && (regSel[0] ^ blockAMask[2]) && firmwareEventEnable;
    endsequence
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    AST_WIDTH: assert property (
        timerWidthFlag == timerWide) else $error("width flag wrong");
    AST_CTLZERO: assert property (
        sRdCtl |-> ##1 rdData[31:13] == 19'h0 && rdData[9:2] == 8'h00)
        else $error("control read bits not zero");
    AST_TMRHI: assert property (
        sRdTmr |-> ##1 rdData[31:24] == 8'h00)
        else $error("timer upper byte not zero");
    AST_ARBWR: assert property (
        sWrArb |-> ##1 arbiterDisable == $past(wrData[0], 2))
        else $error("arbiter bit not written");
    AST_SLPA: assert property (
        sWrTypA |-> ##1 sleepTypeA == $past(wrData[12:10], 2))
        else $error("sleep type not written");
    AST_TRIG: assert property (
        sTrig |-> ##[1:3] sleepStart) else $error("no sleep start");
    AST_PULSE: assert property (
        sleepStart |=> !sleepStart) else $error("sleep start too long");
    AST_RLS: assert property (
        sRls |-> ##[1:3] smiEvent) else $error("no release event");
    AST_TSTKY: assert property (
        timerStatusFlag && !timerStsClr |=> timerStatusFlag)
        else $error("timer status lost");
    AST_FWSTKY: assert property (
        firmwareEventStatus && !firmwareStsClr |=> firmwareEventStatus)
        else $error("firmware status lost");
endmodule // pmfct_props
bind pmfct_top pmfct_props u_props (
    .clk_sys             (clk_sys),
    .sys_rst             (sys_rst),
    .regRead             (regRead),
    .regWrite            (regWrite),
    .regSel              (regSel),
    .byteEn              (byteEn),
    .wrData              (wrData),
    .rdData              (rdData),
    .timerWide           (timerWide),
    .blockAMask          (blockAMask),
    .timerStsClr         (timerStsClr),
    .firmwareEventEnable (firmwareEventEnable),
    .firmwareStsClr      (firmwareStsClr),
    .timerWidthFlag      (timerWidthFlag),
    .smiEvent            (smiEvent),
    .sleepStart          (sleepStart),
    .sleepTypeA          (sleepTypeA),
    .timerStatusFlag     (timerStatusFlag),
    .firmwareEventStatus (firmwareEventStatus),
    .arbiterDisable      (arbiterDisable)
);
`default_nettype wire

// ==== tb/test_pm_fixed_control_timer.sv ====
// Self-checking bench for the power-management fixed block
`timescale 1ns/1ns
`default_nettype none
module test_pm_fixed_control_timer;
    logic clk_sys = 1'b0, sys_rst = 1'b1, regRead = 1'b0, regWrite = 1'b0;
    logic [1:0] regSel = 2'h0, byteEn = 2'h0;
    logic [15:0] wrData = 16'h0000, blockAMask = 16'h1C06;
    logic timerWide = 1'b0, routeSetPin = 1'b0, routeClrPin = 1'b0;
    logic busMasterReqPin = 1'b0, cpuInC3 = 1'b0, timerEnable = 1'b0;
    logic timerStsClr = 1'b0, firmwareEventEnable = 1'b0;
    logic firmwareStsClr = 1'b0, inWorkingState = 1'b1;
    wire [31:0] rdData;
    wire timerWidthFlag, sciEvent, smiEvent, cpuWakeToC0, sleepStart;
    wire timerStatusFlag, firmwareEventStatus, arbiterDisable;
    wire [2:0] sleepTypeA, sleepTypeB;
    wire [2:0] ev = {cpuWakeToC0, smiEvent, sleepStart};
    int failures = 0, n_checks = 0;
    logic [31:0] t1;
    logic hit;
    logic sciSeen = 1'b0;
    pmfct_top u_dut (
        .clk_sys             (clk_sys),
        .sys_rst             (sys_rst),
        .regRead             (regRead),
        .regWrite            (regWrite),
        .regSel              (regSel),
        .byteEn              (byteEn),
        .wrData              (wrData),
        .rdData              (rdData),
        .timerWide           (timerWide),
        .blockAMask          (blockAMask),
        .routeSetPin         (routeSetPin),
        .routeClrPin         (routeClrPin),
        .busMasterReqPin     (busMasterReqPin),
        .cpuInC3             (cpuInC3),
        .timerEnable         (timerEnable),
        .timerStsClr         (timerStsClr),
        .firmwareEventEnable (firmwareEventEnable),
        .firmwareStsClr      (firmwareStsClr),
        .inWorkingState      (inWorkingState),
        .timerWidthFlag      (timerWidthFlag),
        .sciEvent            (sciEvent),
        .smiEvent            (smiEvent),
        .cpuWakeToC0         (cpuWakeToC0),
        .sleepStart          (sleepStart),
        .sleepTypeA          (sleepTypeA),
        .sleepTypeB          (sleepTypeB),
        .timerStatusFlag     (timerStatusFlag),
        .firmwareEventStatus (firmwareEventStatus),
        .arbiterDisable      (arbiterDisable)
    );
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (sciEvent === 1'b1)
            sciSeen <= 1'b1;
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task print_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wr(input logic [1:0] s, b, input logic [15:0] d);
        regSel = s;
        byteEn = b;
        wrData = d;
        regWrite = 1'b1;
        @(negedge clk_sys);
        regWrite = 1'b0;
    endtask
    task rd(input logic [1:0] s);
        regSel = s;
        byteEn = 2'h3;
        regRead = 1'b1;
        @(negedge clk_sys);
        regRead = 1'b0;
        @(negedge clk_sys);
    endtask
    task waitEv(input int w, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 10 && !seen; i++) begin
            seen = (ev[w] === 1'b1);
            @(negedge clk_sys);
        end
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task tReset;
        rd(2'h0);
        chk("ctrlA", rdData, 0);
        rd(2'h3);
        chk("arb", rdData, 0);
        chk("widthFlag", timerWidthFlag, 0);
    endtask
    task tCtrl;
        wr(2'h0, 2'h3, 16'h3C07);
        waitEv(0, hit);
        chk("trigA", hit, 0);
        chk("fwGate", firmwareEventStatus, 0);
        chk("typeA", sleepTypeA, 3'h7);
        rd(2'h0);
        chk("ctrlA", rdData, 32'h1C02);
        wr(2'h0, 2'h1, 16'h0000);
        rd(2'h0);
        chk("laneA", rdData, 32'h1C00);
        wr(2'h1, 2'h3, 16'h3C07);
        waitEv(0, hit);
        chk("trigB", hit, 1);
        chk("typeB", sleepTypeB, 3'h0);
        rd(2'h1);
        chk("ctrlB", rdData, 0);
    endtask
    task tRoute;
        routeSetPin = 1'b1;
        repeat (4) @(negedge clk_sys);
        routeSetPin = 1'b0;
        repeat (4) @(negedge clk_sys);
        wr(2'h1, 2'h1, 16'h0000);
        rd(2'h1);
        chk("routeSet", rdData, 1);
        routeClrPin = 1'b1;
        repeat (4) @(negedge clk_sys);
        routeClrPin = 1'b0;
        repeat (4) @(negedge clk_sys);
        wr(2'h1, 2'h1, 16'h0001);
        rd(2'h1);
        chk("routeClr", rdData, 0);
    endtask
    task tTimer;
        timerEnable = 1'b1;
        rd(2'h2);
        t1 = rdData;
        repeat (98) @(negedge clk_sys);
        rd(2'h2);
        chk("rate", (rdData - t1) inside {35, 36}, 1);
        chk("upper", rdData[31:24], 0);
        inWorkingState = 1'b0;
        repeat (6) @(negedge clk_sys);
        rd(2'h2);
        t1 = rdData;
        repeat (48) @(negedge clk_sys);
        rd(2'h2);
        chk("held", rdData, t1);
        inWorkingState = 1'b1;
        timerEnable = 1'b0;
        chk("tmrSts", timerStatusFlag, 0);
        chk("sciQuiet", sciSeen, 0);
    endtask
    task tArb;
        wr(2'h3, 2'h1, 16'h0001);
        @(negedge clk_sys);
        chk("arbSet", arbiterDisable, 1);
        rd(2'h3);
        chk("arbRd", rdData, 1);
        wr(2'h3, 2'h1, 16'h0000);
        @(negedge clk_sys);
        chk("arbClr", arbiterDisable, 0);
    endtask
    task tRls;
        firmwareEventEnable = 1'b1;
        wr(2'h0, 2'h1, 16'h0004);
        waitEv(1, hit);
        chk("smi", hit, 1);
        chk("fwSts", firmwareEventStatus, 1);
        firmwareStsClr = 1'b1;
        @(negedge clk_sys);
        firmwareStsClr = 1'b0;
        @(negedge clk_sys);
        chk("fwClr", firmwareEventStatus, 0);
    endtask
    task tWake(input logic en);
        wr(2'h0, 2'h1, {14'h0, en, 1'b0});
        cpuInC3 = 1'b1;
        busMasterReqPin = 1'b1;
        waitEv(2, hit);
        chk("wake", hit, en);
        cpuInC3 = 1'b0;
        busMasterReqPin = 1'b0;
        repeat (8) @(negedge clk_sys);
    endtask
    initial begin
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        tReset;
        tCtrl;
        tRoute;
        tTimer;
        tArb;
        tRls;
        tWake(1'b1);
        tWake(1'b0);
        print_verdict;
    end
    initial begin
        #2000000;
        failures++;
        print_verdict;
    end
endmodule // test_pm_fixed_control_timer
`default_nettype wire
